// ===== rtl/mach_regs.svh
// constants for the memory access command handler
`ifndef MACH_REGS_SVH
`define MACH_REGS_SVH

// command identifiers, low bit marks a reply
`define MACH_ID_READ_REQ 16'h0800
`define MACH_ID_READ_RPL 16'h0801
`define MACH_ID_WRITE_REQ 16'h0802
`define MACH_ID_WRITE_RPL 16'h0803
`define MACH_ID_RPL_FLAG 16'h0001

// reply status codes
`define MACH_ST_SUCCESS 16'h0000
`define MACH_ST_NOT_IMPL 16'h8001
`define MACH_ST_BAD_PARAM 16'h8002
`define MACH_ST_BAD_ADDR 16'h8003
`define MACH_ST_READ_ONLY 16'h8004

// request payload layout, byte count and bit fields of the capture vector
`define MACH_RD_REQ_LEN 16'h000C
`define MACH_WR_ADDR_LEN 16'h0008
`define MACH_RD_HDR_LAST 4'hB
`define MACH_WR_HDR_LAST 4'h7
`define MACH_ADDR_MSB 63
`define MACH_ADDR_LSB 0
`define MACH_RSV_MSB 79
`define MACH_RSV_LSB 64
`define MACH_CNT_MSB 95
`define MACH_CNT_LSB 80

// write reply payload: reserved at 0..1, bytes written at 2..3
`define MACH_WR_RPL_LEN 16'h0004
`define MACH_WR_RPL_NONE 16'h0000
`define MACH_RPL_CNT_LO 4'h2
`define MACH_RPL_CNT_HI 4'h3

// software register map
`define MACH_REG_CAP 8'h00
`define MACH_REG_LAST 8'h04
`define MACH_REG_COUNT 8'h08
`define MACH_CAP_LW_BIT 0
`define MACH_CAP_RESET 32'h0000_0001
`define MACH_LAST_BUSY_BIT 16

`endif

// ===== rtl/mach_pkg.sv
// types for the memory access command handler
package mach_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_HDR = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_RD_REQ = 4'b0011,
    ST_RD_WAIT = 4'b0100,
    ST_RD_OUT = 4'b0101,
    ST_WR_DATA = 4'b0110,
    ST_WR_STORE = 4'b0111,
    ST_DRAIN = 4'b1000,
    ST_WA_OUT = 4'b1001,
    ST_DONE = 4'b1010
  } mach_state_t;

endpackage : mach_pkg

// ===== rtl/mach_field_capture.sv
// byte capture of the fixed request payload fields
`timescale 1ns/1ps
module mach_field_capture #(
  parameter int NBYTES = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // byte write
  input wire logic clr,
  input wire logic we,
  input wire logic [3:0] idx,
  input wire logic [7:0] din,
  // captured fields, byte i at bits 8i+7..8i
  output logic [8*NBYTES-1:0] vec
);

  // one byte lane per payload position
  genvar i;
  generate
    for (i = 0; i < NBYTES; i++) begin : g_lane
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          vec[8*i +: 8] <= 8'h00;
        end else if (clr) begin
          vec[8*i +: 8] <= 8'h00;
        end else if (we && (idx == 4'(i))) begin
          vec[8*i +: 8] <= din;
        end
      end
    end
  endgenerate

endmodule : mach_field_capture

// ===== rtl/mach_sw_regs.sv
// software register slave: capability, last outcome, reply count
`timescale 1ns/1ps
`include "mach_regs.svh"
module mach_sw_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // block state
  input wire logic busy,
  input wire logic rpl_done,
  input wire logic [15:0] rpl_status,
  output logic cap_len_written
);

  logic [31:0] cap_r;
  logic [15:0] last_r;
  logic [31:0] count_r;
  logic [31:0] rd_sel;

  // read decode, unmapped reads as zero
  assign rd_sel = (reg_addr == `MACH_REG_CAP) ? cap_r :
                  (reg_addr == `MACH_REG_LAST) ? {15'h0000, busy, last_r} :
                  (reg_addr == `MACH_REG_COUNT) ? count_r : 32'h0000_0000;
  assign cap_len_written = cap_r[`MACH_CAP_LW_BIT];

  // capability write, status capture and read data one cycle later
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cap_r <= `MACH_CAP_RESET;
      last_r <= `MACH_ST_SUCCESS;
      count_r <= 32'h0000_0000;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (reg_wr && (reg_addr == `MACH_REG_CAP)) begin
        cap_r <= reg_wdata & `MACH_CAP_RESET; // only the capability bit is held
      end
      if (rpl_done) begin
        last_r <= rpl_status;
        count_r <= count_r + 32'h0000_0001;
      end
      reg_rdata <= reg_rd ? rd_sel : 32'h0000_0000;
    end
  end

endmodule : mach_sw_regs

// ===== rtl/mach_cmd_handler.sv
// read and write memory request handler with reply builder
// Function
// - read address and count are byte aligned
// - read payload: address@0, reserved@8, count@10
// - read data follows reply header at offset 0
// - short or long read gets explaining status
// - write address and count are byte aligned
// - write payload: address@0, data from offset 8
// - write count comes from header length
// - every write request gets a write reply
// - bytes-written report only when capability set
// - bytes-written report: two bytes at offset 2
// - reserved word sent only with the report
// - reserved word is sent as zeros
// - write reply length is 4 or 0
// - request ids even, reply ids odd
// - missing register address gives status 0x8003
// - write to read-only register gives 0x8004
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "mach_regs.svh"
module mach_cmd_handler
  import mach_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // decoded request header
  input wire logic cmd_start,
  input wire logic [15:0] cmd_id,
  input wire logic [15:0] cmd_len,
  input wire logic [15:0] cmd_req_id,
  output logic busy,
  // request payload bytes
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // reply payload bytes
  output logic [7:0] rpl_data,
  output logic rpl_valid,
  input wire logic rpl_ready,
  // reply header, presented at the end of the reply
  output logic rpl_done,
  output logic [15:0] rpl_id,
  output logic [15:0] rpl_status,
  output logic [15:0] rpl_len,
  output logic [15:0] rpl_req_id,
  // register map byte port
  output logic [63:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_bad_addr,
  input wire logic mem_read_only,
  // software register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  mach_state_t state_r, state_nxt;
  logic [15:0] cmd_id_r, req_id_r;
  logic is_rd_r, is_wr_r, cap_r;
  logic [15:0] rem_r, rem_nxt;
  logic [3:0] pos_r, pos_nxt;
  logic [63:0] addr_r, addr_nxt;
  logic [15:0] left_r, left_nxt;
  logic [15:0] xfer_r, xfer_nxt;
  logic [15:0] status_r, status_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic cap_we, cap_clr;
  logic [95:0] cap_vec;
  logic cap_len_written;

  // reply payload byte of the write reply at a given position
  function automatic logic [7:0] ack_byte(input logic [3:0] pos, input logic [15:0] n);
    logic [7:0] b;
    b = 8'h00; // reserved word stays zero
    if (pos == `MACH_RPL_CNT_LO) begin
      b = n[7:0];
    end else if (pos == `MACH_RPL_CNT_HI) begin
      b = n[15:8];
    end
    return b;
  endfunction : ack_byte

  // request classification on the incoming header
  wire in_is_rd = (cmd_id == `MACH_ID_READ_REQ);
  wire in_is_wr = (cmd_id == `MACH_ID_WRITE_REQ);
  wire in_short = in_is_rd ? (cmd_len != `MACH_RD_REQ_LEN) : (cmd_len < `MACH_WR_ADDR_LEN);
  wire in_empty = (cmd_len == 16'h0000);
  wire take_cmd = cmd_start && (state_r == ST_IDLE);

  // captured payload fields
  wire [63:0] f_addr = cap_vec[`MACH_ADDR_MSB:`MACH_ADDR_LSB];
  wire [15:0] f_rsv = cap_vec[`MACH_RSV_MSB:`MACH_RSV_LSB];
  wire [15:0] f_cnt = cap_vec[`MACH_CNT_MSB:`MACH_CNT_LSB];
  wire [3:0] hdr_last = is_rd_r ? `MACH_RD_HDR_LAST : `MACH_WR_HDR_LAST;

  // where a write ends: report bytes or reply at once
  wire mach_state_t wr_end_st = cap_r ? ST_WA_OUT : ST_DONE;
  wire last_byte = (rem_r == 16'h0001);

  // handshakes and register map strobes
  assign busy = (state_r != ST_IDLE);
  assign in_ready = (state_r == ST_HDR) || (state_r == ST_WR_DATA) || (state_r == ST_DRAIN);
  assign rpl_valid = (state_r == ST_RD_OUT) || (state_r == ST_WA_OUT);
  assign rpl_data = byte_r;
  assign mem_addr = addr_r; // byte addressed
  assign mem_wdata = byte_r;
  assign mem_rd = (state_r == ST_RD_REQ); // every attempt is shown, the map refuses missing bytes
  assign mem_wr = (state_r == ST_WR_STORE); // the map refuses missing or read-only bytes

  // next state and datapath
  always_comb begin
    state_nxt = state_r;
    rem_nxt = rem_r;
    pos_nxt = pos_r;
    addr_nxt = addr_r;
    left_nxt = left_r;
    xfer_nxt = xfer_r;
    status_nxt = status_r;
    byte_nxt = byte_r;
    cap_we = 1'b0;
    cap_clr = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (cmd_start) begin
          rem_nxt = cmd_len;
          pos_nxt = 4'h0;
          xfer_nxt = 16'h0000;
          byte_nxt = 8'h00;
          status_nxt = `MACH_ST_SUCCESS;
          cap_clr = 1'b1;
          if (!in_is_rd && !in_is_wr) begin
            status_nxt = `MACH_ST_NOT_IMPL;
            state_nxt = in_empty ? ST_DONE : ST_DRAIN;
          end else if (in_short) begin
            status_nxt = `MACH_ST_BAD_PARAM;
            state_nxt = in_empty ? (in_is_wr ? (cap_len_written ? ST_WA_OUT : ST_DONE) : ST_DONE) : ST_DRAIN;
          end else begin
            state_nxt = ST_HDR;
          end
        end
      end
      ST_HDR: begin
        if (in_valid) begin
          cap_we = 1'b1;
          pos_nxt = pos_r + 4'h1;
          rem_nxt = rem_r - 16'h0001; // payload left after the fields
          if (pos_r == hdr_last) begin
            state_nxt = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        addr_nxt = f_addr;
        left_nxt = f_cnt;
        pos_nxt = 4'h0;
        if (is_rd_r) begin
          if (f_rsv != 16'h0000) begin
            status_nxt = `MACH_ST_BAD_PARAM;
            state_nxt = ST_DONE;
          end else begin
            state_nxt = (f_cnt == 16'h0000) ? ST_DONE : ST_RD_REQ;
          end
        end else begin
          state_nxt = (rem_r == 16'h0000) ? wr_end_st : ST_WR_DATA;
        end
      end
      ST_RD_REQ: begin
        if (mem_bad_addr) begin
          status_nxt = `MACH_ST_BAD_ADDR; // read stops short
          state_nxt = ST_DONE;
        end else begin
          state_nxt = ST_RD_WAIT;
        end
      end
      ST_RD_WAIT: begin
        byte_nxt = mem_rdata;
        state_nxt = ST_RD_OUT;
      end
      ST_RD_OUT: begin
        if (rpl_ready) begin
          xfer_nxt = xfer_r + 16'h0001;
          addr_nxt = addr_r + 64'h0000_0000_0000_0001;
          left_nxt = left_r - 16'h0001;
          state_nxt = (left_r == 16'h0001) ? ST_DONE : ST_RD_REQ;
        end
      end
      ST_WR_DATA: begin
        if (in_valid) begin
          byte_nxt = in_data; // data from payload offset 8
          rem_nxt = rem_r - 16'h0001;
          state_nxt = ST_WR_STORE;
        end
      end
      ST_WR_STORE: begin
        byte_nxt = 8'h00;
        if (mem_bad_addr || mem_read_only) begin
          status_nxt = mem_bad_addr ? `MACH_ST_BAD_ADDR : `MACH_ST_READ_ONLY;
          state_nxt = (rem_r == 16'h0000) ? wr_end_st : ST_DRAIN;
        end else begin
          xfer_nxt = xfer_r + 16'h0001;
          addr_nxt = addr_r + 64'h0000_0000_0000_0001;
          state_nxt = (rem_r == 16'h0000) ? wr_end_st : ST_WR_DATA;
        end
      end
      ST_DRAIN: begin
        if (in_valid) begin
          rem_nxt = rem_r - 16'h0001;
          pos_nxt = 4'h0;
          byte_nxt = 8'h00;
          if (last_byte) begin
            state_nxt = is_wr_r ? wr_end_st : ST_DONE;
          end
        end
      end
      ST_WA_OUT: begin
        if (rpl_ready) begin
          pos_nxt = pos_r + 4'h1;
          byte_nxt = ack_byte(pos_r + 4'h1, xfer_r);
          if (pos_r == `MACH_RPL_CNT_HI) begin
            state_nxt = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // reply header length: returned bytes on read, 4 or 0 on write
  wire [15:0] len_sel = is_rd_r ? xfer_r :
                        (is_wr_r && cap_r) ? `MACH_WR_RPL_LEN : `MACH_WR_RPL_NONE;

  // state and working registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      rem_r <= 16'h0000;
      pos_r <= 4'h0;
      addr_r <= 64'h0000_0000_0000_0000;
      left_r <= 16'h0000;
      xfer_r <= 16'h0000;
      status_r <= `MACH_ST_SUCCESS;
      byte_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      rem_r <= rem_nxt;
      pos_r <= pos_nxt;
      addr_r <= addr_nxt;
      left_r <= left_nxt;
      xfer_r <= xfer_nxt;
      status_r <= status_nxt;
      byte_r <= byte_nxt;
    end
  end

  // request header latch, capability sampled once per request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_id_r <= 16'h0000;
      req_id_r <= 16'h0000;
      is_rd_r <= 1'b0;
      is_wr_r <= 1'b0;
      cap_r <= 1'b0;
    end else if (take_cmd) begin
      cmd_id_r <= cmd_id;
      req_id_r <= cmd_req_id;
      is_rd_r <= in_is_rd;
      is_wr_r <= in_is_wr;
      cap_r <= cap_len_written;
    end
  end

  // reply header outputs, done is a one-cycle pulse
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rpl_done <= 1'b0;
      rpl_id <= 16'h0000;
      rpl_status <= `MACH_ST_SUCCESS;
      rpl_len <= 16'h0000;
      rpl_req_id <= 16'h0000;
    end else begin
      rpl_done <= (state_r == ST_DONE);
      if (state_r == ST_DONE) begin
        rpl_id <= cmd_id_r | `MACH_ID_RPL_FLAG;
        rpl_status <= status_r;
        rpl_len <= len_sel;
        rpl_req_id <= req_id_r;
      end
    end
  end

  // payload field capture
  mach_field_capture #(
    .NBYTES(12)
  ) u_capture (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(cap_clr),
    .we(cap_we),
    .idx(pos_r),
    .din(in_data),
    .vec(cap_vec)
  );

  // software registers
  mach_sw_regs u_regs (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .busy(busy),
    .rpl_done(rpl_done),
    .rpl_status(rpl_status),
    .cap_len_written(cap_len_written)
  );

endmodule : mach_cmd_handler

// ===== test/mach_cmd_handler_asserts.sv
// assertion checker for the memory access command handler
`timescale 1ns/1ps
module mach_cmd_handler_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // request and reply
  input wire logic cmd_start,
  input wire logic [15:0] cmd_id,
  input wire logic busy,
  input wire logic [7:0] rpl_data,
  input wire logic rpl_valid,
  input wire logic rpl_ready,
  input wire logic rpl_done,
  input wire logic [15:0] rpl_id,
  input wire logic [15:0] rpl_status,
  input wire logic [15:0] rpl_len,
  // register map
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic mem_bad_addr,
  input wire logic mem_read_only
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  logic [15:0] beat_r;
  logic [15:0] stored_r;
  logic is_wr_r;
  wire beat = rpl_valid && rpl_ready;
  wire taken = cmd_start && !busy;
  wire stored = mem_wr && !mem_bad_addr && !mem_read_only;
  // reply bytes since last reply, bytes stored and kind of request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      beat_r <= 16'h0000;
      stored_r <= 16'h0000;
      is_wr_r <= 1'b0;
    end else begin
      beat_r <= rpl_done ? 16'h0000 : beat_r + 16'(beat);
      stored_r <= taken ? 16'h0000 : stored_r + 16'(stored);
      is_wr_r <= taken ? (cmd_id == 16'h0802) : is_wr_r;
    end
  end
  reply_id_odd_a:
    assert property (rpl_done |-> rpl_id[0]) else $error("reply id lacks reply flag");
  reply_len_a:
    assert property (rpl_done |-> rpl_len == beat_r) else $error("reply length differs from bytes sent");
  write_len_a:
    assert property (rpl_done && rpl_id == 16'h0803 |-> rpl_len inside {16'h0000, 16'h0004})
      else $error("write reply length not 0 or 4");
  reserved_zero_a:
    assert property (beat && is_wr_r && beat_r < 16'h0002 |-> rpl_data == 8'h00) else $error("reserved not zero");
  written_count_a:
    assert property (beat && is_wr_r && beat_r == 16'h0002 |-> rpl_data == stored_r[7:0])
      else $error("bytes written report wrong");
  bad_addr_a:
    assert property ((mem_rd || mem_wr) && mem_bad_addr |-> ##[1:60] rpl_done && rpl_status == 16'h8003)
      else $error("bad address not reported");
  read_only_a:
    assert property (mem_wr && mem_read_only && !mem_bad_addr |-> ##[1:60] rpl_done && rpl_status == 16'h8004)
      else $error("read-only write not reported");
  write_reply_a:
    assert property (taken && cmd_id == 16'h0802 |-> ##[1:300] rpl_done && rpl_id == 16'h0803)
      else $error("write request without write reply");
  cover property (rpl_done && rpl_id == 16'h0801);
  cover property (rpl_done && rpl_id == 16'h0803 && rpl_len == 16'h0004);
  cover property (rpl_done && rpl_status == 16'h8004);
endmodule : mach_cmd_handler_asserts

bind mach_cmd_handler mach_cmd_handler_asserts u_mach_cmd_handler_asserts (.sys_clk, .resetn, .cmd_start,
  .cmd_id, .busy, .rpl_data, .rpl_valid, .rpl_ready, .rpl_done, .rpl_id, .rpl_status, .rpl_len, .mem_wr,
  .mem_rd, .mem_bad_addr, .mem_read_only);

// ===== test/mach_mem_model.sv
// register map model: 16 bytes, top four read-only, rest missing
`timescale 1ns/1ps
module mach_mem_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // byte port
  input wire logic [63:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_bad_addr,
  output logic mem_read_only
);
  logic [7:0] cell_r [16];
  wire hit = mem_addr < 64'd16;
  // address decode answers in the strobe cycle
  assign mem_bad_addr = !hit;
  assign mem_read_only = hit && mem_addr >= 64'd12;
  // data is valid only the cycle after a read, otherwise it keeps changing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) cell_r[i] <= 8'h50 + 8'(i);
      mem_rdata <= 8'h00;
    end else begin
      if (mem_wr && hit && !mem_read_only) cell_r[mem_addr[3:0]] <= mem_wdata;
      mem_rdata <= (mem_rd && hit) ? cell_r[mem_addr[3:0]] : ~mem_rdata;
    end
  end
endmodule : mach_mem_model

// ===== test/mach_cmd_handler_test.sv
// self-checking bench for the memory access command handler
`timescale 1ns/1ps
`include "mach_regs.svh"
module mach_cmd_handler_test;
  logic sys_clk, resetn, cmd_start, in_valid, rpl_ready, reg_wr, reg_rd, slow;
  logic busy, in_ready, rpl_valid, rpl_done, mem_rd, mem_wr, mem_bad_addr, mem_read_only;
  logic [15:0] cmd_id, cmd_len, cmd_req_id, rpl_id, rpl_status, rpl_len, rpl_req_id;
  logic [7:0] in_data, reg_addr, mem_rdata, rpl_data, mem_wdata;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [63:0] mem_addr;
  logic [7:0] pl[$];
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  int num_errors = 0;
  int total_checks = 0;
  int nrpl = 0;
  mach_cmd_handler u_mach_cmd_handler (.sys_clk, .resetn, .cmd_start, .cmd_id, .cmd_len, .cmd_req_id, .busy,
    .in_data, .in_valid, .in_ready, .rpl_data, .rpl_valid, .rpl_ready, .rpl_done, .rpl_id, .rpl_status,
    .rpl_len, .rpl_req_id, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .mem_bad_addr,
    .mem_read_only, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  mach_mem_model u_mach_mem_model (.sys_clk, .resetn, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
    .mem_bad_addr, .mem_read_only);
  // clock and reply consumer that stalls every other cycle when slow
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) rpl_ready <= slow ? ~rpl_ready : 1'b1;
  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask : reg_read
  // payload builders, little endian
  task automatic put64(input logic [63:0] v);
    for (int i = 0; i < 8; i++) pl.push_back(v[8*i +: 8]);
  endtask : put64
  task automatic put16(input logic [15:0] v);
    pl.push_back(v[7:0]);
    pl.push_back(v[15:8]);
  endtask : put16
  // one request: header, payload stream, then the reply collected and compared
  task automatic req(input logic [15:0] id, input logic [15:0] st);
    logic ok;
    @(posedge sys_clk);
    cmd_start <= 1'b1;
    cmd_id <= id;
    cmd_len <= 16'(pl.size());
    cmd_req_id <= cmd_req_id + 16'h0001;
    @(posedge sys_clk);
    cmd_start <= 1'b0;
    foreach (pl[i]) begin
      in_valid <= 1'b1;
      in_data <= pl[i];
      do begin
        @(negedge sys_clk);
        ok = in_ready;
        @(posedge sys_clk);
      end while (ok !== 1'b1);
    end
    in_valid <= 1'b0;
    got_q.delete();
    do begin
      @(negedge sys_clk);
      if (rpl_valid && rpl_ready) got_q.push_back(rpl_data);
    end while (rpl_done !== 1'b1);
    nrpl++;
    if (id[15:1] == 15'h0400 || id[15:1] == 15'h0401) check(rpl_id, id | `MACH_ID_RPL_FLAG);
    else check(rpl_id[0], 1'b1);
    check(rpl_status, st);
    check(rpl_len, 64'(exp_q.size()));
    check(rpl_req_id, cmd_req_id);
    check(64'(got_q.size()), 64'(exp_q.size()));
    foreach (exp_q[i]) check(got_q[i], exp_q[i]);
    pl.delete();
  endtask : req
  initial begin
    {resetn, cmd_start, in_valid, reg_wr, reg_rd, slow} = 6'b000000;
    {cmd_id, cmd_len, cmd_req_id, in_data, reg_addr, reg_wdata} = '0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    reg_read(`MACH_REG_CAP, d);
    check(d, 32'h0000_0001);
    reg_read(8'h0C, d);
    check(d, 32'h0000_0000);
    // three byte read with a stalling consumer
    slow = 1'b1;
    put64(64'h2);
    put16(16'h0);
    put16(16'h3);
    exp_q = '{8'h52, 8'h53, 8'h54};
    req(`MACH_ID_READ_REQ, `MACH_ST_SUCCESS);
    slow = 1'b0;
    // read running off the end of the map returns what was read
    put64(64'hE);
    put16(16'h0);
    put16(16'h4);
    exp_q = '{8'h5E, 8'h5F};
    req(`MACH_ID_READ_REQ, `MACH_ST_BAD_ADDR);
    // reserved field not zero
    put64(64'h0);
    put16(16'h1);
    put16(16'h1);
    exp_q.delete();
    req(`MACH_ID_READ_REQ, `MACH_ST_BAD_PARAM);
    // two byte write, count taken from header length, then read back
    put64(64'h4);
    pl.push_back(8'hCA);
    pl.push_back(8'hFE);
    exp_q = '{8'h00, 8'h00, 8'h02, 8'h00};
    req(`MACH_ID_WRITE_REQ, `MACH_ST_SUCCESS);
    put64(64'h4);
    put16(16'h0);
    put16(16'h2);
    exp_q = '{8'hCA, 8'hFE};
    req(`MACH_ID_READ_REQ, `MACH_ST_SUCCESS);
    // write crossing into read-only bytes stops there
    put64(64'hB);
    pl.push_back(8'h11);
    pl.push_back(8'h22);
    exp_q = '{8'h00, 8'h00, 8'h01, 8'h00};
    req(`MACH_ID_WRITE_REQ, `MACH_ST_READ_ONLY);
    put64(64'hB);
    put16(16'h0);
    put16(16'h2);
    exp_q = '{8'h11, 8'h5C};
    req(`MACH_ID_READ_REQ, `MACH_ST_SUCCESS);
    // write to a missing address
    put64(64'h20);
    pl.push_back(8'h33);
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h00};
    req(`MACH_ID_WRITE_REQ, `MACH_ST_BAD_ADDR);
    // report switched off, only the capability bit is held: empty write reply
    reg_write(`MACH_REG_CAP, 32'hFFFF_FFFE);
    reg_read(`MACH_REG_CAP, d);
    check(d, 32'h0000_0000);
    put64(64'h0);
    pl.push_back(8'h77);
    exp_q.delete();
    req(`MACH_ID_WRITE_REQ, `MACH_ST_SUCCESS);
    // unknown command is drained and refused
    put64(64'h0);
    req(16'h0804, `MACH_ST_NOT_IMPL);
    reg_read(`MACH_REG_COUNT, d);
    check(d, 32'(nrpl));
    reg_read(`MACH_REG_LAST, d);
    check(d, 32'h0000_8001);
    summarize();
  end
  // watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    summarize();
  end
endmodule : mach_cmd_handler_test
